// ==== ddr_init_defs.vh ====
/*
  Constants shared by the power-up sequencer of the DDR/DDR2 memory controller:
  register offsets, field positions, reset values and timing figures.
  Assumes a 250 MHz pclk and a 12-bit APB byte address.
*/
// How it works
// R01 - DDR order: wait, precharge, ext load, mode load, wait, precharge, two refresh, load.
// R02 - DDR holds NOP from reset for the startup time, shortened by parameter.
// R03 - DDR: after the DLL-resetting mode load, 200 cycles pass before the next command.
// R04 - every precharge drives the all-banks address bit high, a10 or a8.
// R05 - extended load is a mode load with bank bits set; first enables DLL.
// R06 - DDR first mode load sets latency and burst and resets the DLL.
// R07 - DDR second precharge, exactly two refreshes, then mode load with DLL reset clear.
// R08 - init done rises once either sequence has completed.
// R09 - DDR2 order: precharge, ext 2, 3, 1, load, precharge, refreshes, load, ext 1 twice.
// R10 - DDR2 raises clock enable after a programmable startup delay from reset.
// R11 - DDR2 waits startup count over 500, at least one cycle, before precharge.
// R12 - DDR2 loads extended registers 2 then 3 with all zeros.
// R13 - DDR2 ext load 1 enables DLL, then mode load resets the DLL.
// R14 - DDR2 after DLL reset: precharge, two refreshes, mode load with reset clear.
// R15 - 200 cycles after DLL reset, two ext loads to register 1 set driver default, then exit it.
// R16 - with extra pipeline on, command outputs run on the address/command clock.
// R17 - a dedicated capture clock may replace the data strobe for read capture.
// R18 - the outside DLL supplies a six-bit strobe delay control bus.
// R19 - the outside DLL supplies an update strobe gating when delay may change.
// R20 - reset may assert at any time but is released on a rising pclk edge.
// R21 - commands use standard row, column and write strobe coding, chip selects low.
// R22 - init done stays low and user access is barred until the final command.
`ifndef DDR_INIT_DEFS_VH
`define DDR_INIT_DEFS_VH

`define CLK_PERIOD_NS    4
`define DDR_STARTUP_MS   200
`define DDR2_STARTUP_US  200
`define DLL_LOCK_CYC     200
`define CKE_DIV          500
`define CMD_GAP_NS       128

`define OFS_CTRL         12'h000
`define OFS_MODE         12'h004
`define OFS_EMODE        12'h008
`define OFS_STATUS       12'h00C

`define CTRL_START_BIT   0
`define CTRL_DDR2_BIT    1
`define CTRL_CAPSEL_BIT  2
`define CTRL_RST         3'h0
`define MODE_RST         13'h0032
`define EMODE_RST        13'h0000

`define MR_DLL_RST_BIT   8
`define EMR_DLL_DIS_BIT  0
`define EMR_OCD_LSB      7
`define OCD_DEFAULT      3'h7
`define OCD_EXIT         3'h0

`define BA_MR            2'h0
`define BA_EMR1          2'h1
`define BA_EMR2          2'h2
`define BA_EMR3          2'h3

`define ST_DONE_BIT      0
`define ST_CKE_BIT       1
`define ST_STATE_LSB     4
`define ST_STEP_LSB      8
`define ST_DQS_LSB       16

`endif

// ==== cmd_out_reg.v ====
/*
  Address and command output register stage toward the memory pins.
  Assumes its clock is pclk or a phase-shifted copy of it at the same rate.
*/
`timescale 1ns/1ns
`default_nettype none
module cmd_out_reg #(
  parameter CS = 1,
  parameter AW = 13
) (
  input  wire          clk,      // pclk or address/command clock
  input  wire          rst_n,    // asynchronous reset, active low
  input  wire          ce,       // clock enable
  input  wire          cke_in,   // clock enable to memory
  input  wire          ras_in,   // row strobe, active low
  input  wire          cas_in,   // column strobe, active low
  input  wire          we_in,    // write enable, active low
  input  wire [1:0]    ba_in,    // bank address
  input  wire [AW-1:0] addr_in,  // address
  output reg           cke,      // registered clock enable
  output reg  [CS-1:0] cs_n,     // chip selects, active low
  output reg           ras_n,    // registered row strobe
  output reg           cas_n,    // registered column strobe
  output reg           we_n,     // registered write enable
  output reg  [1:0]    ba,       // registered bank address
  output reg  [AW-1:0] addr      // registered address
);
  // reset parks the pins on NOP with the memory clock disabled
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cke   <= 1'b0;
      cs_n  <= {CS{1'b0}};
      ras_n <= 1'b1;
      cas_n <= 1'b1;
      we_n  <= 1'b1;
      ba    <= 2'h0;
      addr  <= {AW{1'b0}};
    end else if (ce) begin
      cke   <= cke_in;
      cs_n  <= {CS{1'b0}}; // see R21
      ras_n <= ras_in;
      cas_n <= cas_in;
      we_n  <= we_in;
      ba    <= ba_in;
      addr  <= addr_in;
    end
  end
endmodule
`default_nettype wire

// ==== ddr_sdram_init_sequencer.v ====
/*
  Power-up initialisation sequencer for DDR and DDR2 memory, with an APB
  register slave, strobe delay control resynchronisation and the command pin stage.
  Assumes presetn is released on a rising pclk edge and addrcmd_clk, when
  used, runs at pclk rate with a fixed phase.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ddr_init_defs.vh"
module ddr_sdram_init_sequencer #(
  parameter        CS           = 1,
  parameter        AW           = 13,
  parameter        PCH_BIT      = 10,
  parameter        EXTRA_PIPE   = 0,
  parameter        USE_DQS_UPD  = 1,
  parameter [31:0] DDR_STARTUP  = ((`DDR_STARTUP_MS * 1000000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter [31:0] DDR2_STARTUP = ((`DDR2_STARTUP_US * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire          pclk,            // system clock
  input  wire          presetn,         // asynchronous reset, active low
  input  wire          ce,              // clock enable, freezes all state when low
  input  wire          psel,            // APB select
  input  wire          penable,         // APB enable
  input  wire          pwrite,          // APB write
  input  wire [11:0]   paddr,           // APB byte address
  input  wire [31:0]   pwdata,          // APB write data
  output reg  [31:0]   prdata,          // APB read data
  output wire          pready,          // APB ready
  output reg           pslverr,         // APB error for unmapped address
  input  wire          addrcmd_clk,     // address/command clock for extra pipeline
  input  wire [5:0]    dqs_delay_ctrl,  // strobe delay from outside DLL
  input  wire          dqsupdate,       // delay update strobe from outside DLL
  output reg  [5:0]    dqs_delay_out,   // delay setting toward strobe pins
  output reg           capture_clk_sel, // selects capture clock over strobe
  output wire          mem_cke,         // memory clock enable
  output wire [CS-1:0] mem_cs_n,        // memory chip selects, active low
  output wire          mem_ras_n,       // memory row strobe, active low
  output wire          mem_cas_n,       // memory column strobe, active low
  output wire          mem_we_n,        // memory write enable, active low
  output wire [1:0]    mem_ba,          // memory bank address
  output wire [AW-1:0] mem_addr,        // memory address
  output reg           init_done        // memory ready for user traffic
);
  localparam [31:0] CKE_WAIT = (DDR2_STARTUP / `CKE_DIV < 1) ? 32'd1 : DDR2_STARTUP / `CKE_DIV;
  localparam [31:0] GAP_CYC  = (`CMD_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [31:0] DLL_WAIT_W = `DLL_LOCK_CYC - 1;
  localparam [7:0]  DLL_WAIT   = DLL_WAIT_W[7:0];

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_START = 3'h1;
  localparam [2:0] S_CKE   = 3'h2;
  localparam [2:0] S_ISSUE = 3'h3;
  localparam [2:0] S_GAP   = 3'h4;
  localparam [2:0] S_DONE  = 3'h5;

  localparam [3:0] I_PCH  = 4'h0;
  localparam [3:0] I_EMR1 = 4'h1;
  localparam [3:0] I_EMR2 = 4'h2;
  localparam [3:0] I_EMR3 = 4'h3;
  localparam [3:0] I_MRR  = 4'h4;
  localparam [3:0] I_ARF  = 4'h5;
  localparam [3:0] I_MR   = 4'h6;
  localparam [3:0] I_OCDD = 4'h7;
  localparam [3:0] I_OCDX = 4'h8;

  // command list per memory type
  function [3:0] step_item;
    input       ddr2;
    input [3:0] s;
    begin
      step_item = I_PCH;
      if (ddr2) begin
        case (s) // see R09
          4'h0: step_item = I_PCH;
          4'h1: step_item = I_EMR2; // see R12
          4'h2: step_item = I_EMR3;
          4'h3: step_item = I_EMR1; // see R13
          4'h4: step_item = I_MRR;
          4'h5: step_item = I_PCH;  // see R14
          4'h6: step_item = I_ARF;
          4'h7: step_item = I_ARF;
          4'h8: step_item = I_MR;
          4'h9: step_item = I_OCDD; // see R15
          4'hA: step_item = I_OCDX;
          default: step_item = I_PCH;
        endcase
      end else begin
        case (s) // see R01
          4'h0: step_item = I_PCH;
          4'h1: step_item = I_EMR1;
          4'h2: step_item = I_MRR;
          4'h3: step_item = I_PCH;  // see R07
          4'h4: step_item = I_ARF;
          4'h5: step_item = I_ARF;
          4'h6: step_item = I_MR;
          default: step_item = I_PCH;
        endcase
      end
    end
  endfunction

  // {ras_n, cas_n, we_n}
  function [2:0] item_pins;
    input [3:0] it;
    begin
      case (it) // see R21
        I_PCH:   item_pins = 3'h2;
        I_ARF:   item_pins = 3'h1;
        default: item_pins = 3'h0;
      endcase
    end
  endfunction

  function addr_is;
    input [11:0] a;
    input [11:0] ofs;
    begin
      addr_is = (a == ofs);
    end
  endfunction

  reg  [2:0]    ctrl;
  reg  [AW-1:0] mode_val;
  reg  [AW-1:0] emode_val;
  reg  [2:0]    state;
  reg  [31:0]   tmr;
  reg  [3:0]    step;
  reg  [7:0]    dll_cnt;
  reg           is_ddr2;
  reg           cke_q;
  reg  [5:0]    dqs_s1;
  reg  [5:0]    dqs_s2;
  reg           upd_s1;
  reg           upd_s2;
  reg  [31:0]   next_rdata;
  reg           cmd_ras;
  reg           cmd_cas;
  reg           cmd_we;
  reg  [1:0]    cmd_ba;
  reg  [AW-1:0] cmd_addr;
  wire [3:0]    item      = step_item(is_ddr2, step);
  wire [3:0]    last_step = is_ddr2 ? 4'hA : 4'h6;
  wire          dll_ok    = (dll_cnt >= DLL_WAIT);
  wire          need_dll  = is_ddr2 ? (item == I_OCDD) : (step == 4'h3);
  wire          setup     = psel & ~penable & ce;
  wire          wr        = psel & penable & pwrite & ce;
  wire          mapped    = addr_is(paddr, `OFS_CTRL) | addr_is(paddr, `OFS_MODE) |
                            addr_is(paddr, `OFS_EMODE) | addr_is(paddr, `OFS_STATUS);
  wire          ac_clk;

  // zero-wait slave; a low clock enable stalls the access phase
  assign pready = ce;

  always @* begin
    next_rdata = 32'h0;
    if (addr_is(paddr, `OFS_CTRL)) begin
      next_rdata[2:0] = ctrl;
    end else if (addr_is(paddr, `OFS_MODE)) begin
      next_rdata[AW-1:0] = mode_val;
    end else if (addr_is(paddr, `OFS_EMODE)) begin
      next_rdata[AW-1:0] = emode_val;
    end else if (addr_is(paddr, `OFS_STATUS)) begin
      next_rdata[`ST_DONE_BIT]             = init_done;
      next_rdata[`ST_CKE_BIT]              = cke_q;
      next_rdata[`ST_STATE_LSB +: 3]       = state;
      next_rdata[`ST_STEP_LSB +: 4]        = step;
      next_rdata[`ST_DQS_LSB +: 6]         = dqs_delay_out;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= `CTRL_RST;
      mode_val  <= `MODE_RST;
      emode_val <= `EMODE_RST;
      prdata    <= 32'h0;
      pslverr   <= 1'b0;
    end else if (ce) begin
      if (setup) begin
        prdata  <= next_rdata;
        pslverr <= ~mapped;
      end
      if (wr && addr_is(paddr, `OFS_CTRL)) begin
        ctrl <= pwdata[2:0];
      end
      if (wr && addr_is(paddr, `OFS_MODE)) begin
        mode_val <= pwdata[AW-1:0];
      end
      if (wr && addr_is(paddr, `OFS_EMODE)) begin
        emode_val <= pwdata[AW-1:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_clk_sel <= 1'b0;
    end else if (ce) begin
      capture_clk_sel <= ctrl[`CTRL_CAPSEL_BIT]; // see R17
    end
  end

  // delay word is slow-changing; the update strobe keeps it from moving mid-read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dqs_s1        <= 6'h00;
      dqs_s2        <= 6'h00;
      upd_s1        <= 1'b0;
      upd_s2        <= 1'b0;
      dqs_delay_out <= 6'h00;
    end else if (ce) begin
      dqs_s1 <= dqs_delay_ctrl; // see R18
      dqs_s2 <= dqs_s1;
      upd_s1 <= dqsupdate;      // see R19
      upd_s2 <= upd_s1;
      if (USE_DQS_UPD == 0 || upd_s2) begin
        dqs_delay_out <= dqs_s2;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= S_IDLE;
      tmr       <= 32'h0;
      step      <= 4'h0;
      dll_cnt   <= 8'h0;
      is_ddr2   <= 1'b0;
      cke_q     <= 1'b0;
      init_done <= 1'b0;
    end else if (ce) begin
      if (dll_cnt != 8'hFF && dll_cnt < DLL_WAIT) begin
        dll_cnt <= dll_cnt + 8'h1;
      end
      case (state)
        S_IDLE: begin
          if (ctrl[`CTRL_START_BIT]) begin
            is_ddr2 <= ctrl[`CTRL_DDR2_BIT];
            tmr     <= (ctrl[`CTRL_DDR2_BIT] ? DDR2_STARTUP : DDR_STARTUP) - 32'h1; // see R02
            cke_q   <= ~ctrl[`CTRL_DDR2_BIT];
            state   <= S_START;
          end
        end
        S_START: begin
          if (tmr == 32'h0) begin
            if (is_ddr2) begin
              cke_q <= 1'b1;             // see R10
              tmr   <= CKE_WAIT - 32'h1; // see R11
              state <= S_CKE;
            end else begin
              state <= S_ISSUE;
            end
          end else begin
            tmr <= tmr - 32'h1;
          end
        end
        S_CKE: begin
          if (tmr == 32'h0) begin
            state <= S_ISSUE;
          end else begin
            tmr <= tmr - 32'h1;
          end
        end
        S_ISSUE: begin
          if (item == I_MRR) begin
            dll_cnt <= 8'h1; // see R03
          end
          if (step == last_step) begin
            init_done <= 1'b1; // see R08
            state     <= S_DONE;
          end else begin
            step  <= step + 4'h1;
            tmr   <= GAP_CYC - 32'h1;
            state <= S_GAP;
          end
        end
        S_GAP: begin
          if (tmr != 32'h0) begin
            tmr <= tmr - 32'h1;
          end
          // dll wait is checked against the step just advanced to
          if (tmr == 32'h0 && (!need_dll || dll_ok)) begin
            state <= S_ISSUE; // see R15
          end
        end
        S_DONE: begin
          init_done <= 1'b1; // see R22
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // pins default to NOP outside the one issue cycle of each command
  always @* begin
    cmd_ras  = 1'b1;
    cmd_cas  = 1'b1;
    cmd_we   = 1'b1;
    cmd_ba   = `BA_MR;
    cmd_addr = {AW{1'b0}};
    if (state == S_ISSUE) begin
      {cmd_ras, cmd_cas, cmd_we} = item_pins(item);
      case (item)
        I_PCH: begin
          cmd_addr[PCH_BIT] = 1'b1; // see R04
        end
        I_EMR1: begin
          cmd_ba                     = `BA_EMR1; // see R05
          cmd_addr                   = emode_val;
          cmd_addr[`EMR_DLL_DIS_BIT] = 1'b0;
          cmd_addr[`EMR_OCD_LSB +: 3] = `OCD_EXIT;
        end
        I_EMR2: begin
          cmd_ba = `BA_EMR2;
        end
        I_EMR3: begin
          cmd_ba = `BA_EMR3;
        end
        I_MRR: begin
          cmd_addr                  = mode_val; // see R06
          cmd_addr[`MR_DLL_RST_BIT] = 1'b1;
        end
        I_MR: begin
          cmd_addr                  = mode_val; // see R07
          cmd_addr[`MR_DLL_RST_BIT] = 1'b0;
        end
        I_OCDD, I_OCDX: begin
          cmd_ba                      = `BA_EMR1;
          cmd_addr                    = emode_val;
          cmd_addr[`EMR_DLL_DIS_BIT]  = 1'b0;
          cmd_addr[`EMR_OCD_LSB +: 3] = (item == I_OCDD) ? `OCD_DEFAULT : `OCD_EXIT;
        end
        default: begin
          cmd_addr = {AW{1'b0}};
        end
      endcase
    end
  end

  // static clock choice; only a same-rate, fixed-phase clock is safe here
  generate
    if (EXTRA_PIPE != 0) begin : g_ac
      assign ac_clk = addrcmd_clk; // see R16
    end else begin : g_sys
      assign ac_clk = pclk;
    end
  endgenerate

  cmd_out_reg #(
    .CS (CS),
    .AW (AW)
  ) u_cmd_out (
    .clk     (ac_clk),
    .rst_n   (presetn),
    .ce      (ce),
    .cke_in  (cke_q),
    .ras_in  (cmd_ras),
    .cas_in  (cmd_cas),
    .we_in   (cmd_we),
    .ba_in   (cmd_ba),
    .addr_in (cmd_addr),
    .cke     (mem_cke),
    .cs_n    (mem_cs_n),
    .ras_n   (mem_ras_n),
    .cas_n   (mem_cas_n),
    .we_n    (mem_we_n),
    .ba      (mem_ba),
    .addr    (mem_addr)
  );
endmodule
`default_nettype wire

// ==== seq_props.sv ====
/* port checker for the init sequencer: command pins and done flag.
   bound from the testbench; one pclk domain, presetn async low. */
`timescale 1ns/1ns
`default_nettype none
module seq_props #(
  parameter CS      = 1,
  parameter AW      = 13,
  parameter PCH_BIT = 10
) (
  input wire logic          pclk,      // clock
  input wire logic          presetn,   // reset, active low
  input wire logic          mem_cke,   // memory clock enable
  input wire logic [CS-1:0] mem_cs_n,  // chip selects
  input wire logic          mem_ras_n, // row strobe
  input wire logic          mem_cas_n, // column strobe
  input wire logic          mem_we_n,  // write enable
  input wire logic [1:0]    mem_ba,    // bank address
  input wire logic [AW-1:0] mem_addr,  // address
  input wire logic          init_done  // ready flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire        cmd = !(mem_ras_n && mem_cas_n && mem_we_n);
  wire        mrs = !mem_ras_n && !mem_cas_n && !mem_we_n;
  logic [7:0] gap;
  logic       seen_mr;
  logic       seen_emr;
  logic       last_dll;
  // gap saturates so the first command after reset passes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap      <= 8'hFF;
      seen_mr  <= 1'b0;
      seen_emr <= 1'b0;
      last_dll <= 1'b0;
    end else if (cmd) begin
      gap      <= 8'h00;
      seen_mr  <= seen_mr | (mrs && mem_ba == 2'h0);
      seen_emr <= seen_emr | (mrs && mem_ba == 2'h1);
      last_dll <= mrs && mem_ba == 2'h0 && mem_addr[8];
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end
  done_holds_a: assert property (init_done |=> init_done)
    else $error("init done dropped");
  done_final_a: assert property ($rose(init_done) |-> mrs && (mem_ba == 2'h1 || (mem_ba == 2'h0 && !mem_addr[8])))
    else $error("init done without final load");
  cs_low_a: assert property (mem_cs_n == {CS{1'b0}})
    else $error("chip select inactive");
  pch_all_a: assert property (!mem_ras_n && mem_cas_n && !mem_we_n |-> mem_addr[PCH_BIT])
    else $error("precharge not to all banks");
  dll_reset_a: assert property (mrs && mem_ba == 2'h0 && !seen_mr |-> mem_addr[8])
    else $error("first mode load without dll reset");
  dll_enable_a: assert property (mrs && mem_ba == 2'h1 && !seen_emr |-> !mem_addr[0])
    else $error("first extended load leaves dll off");
  emr_zero_a: assert property (mrs && mem_ba[1] |-> mem_addr == {AW{1'b0}})
    else $error("extended register 2 or 3 not zero");
  cke_nop_a: assert property (!mem_cke |-> !cmd)
    else $error("command while clock enable low");
  cmd_gap_a: assert property (cmd |-> gap >= 8'd32)
    else $error("commands too close");
  dll_wait_a: assert property (cmd && last_dll |-> gap == 8'd199 || gap == 8'd32)
    else $error("wrong wait after dll reset");
endmodule
`default_nettype wire

// ==== mem_model.sv ====
/* memory device stand-in: logs every command seen on the pins.
   assumes pins registered on pclk; log cleared by reset. */
`timescale 1ns/1ns
`default_nettype none
module mem_model #(
  parameter AW = 13
) (
  input wire logic          pclk,      // clock
  input wire logic          presetn,   // reset, active low
  input wire logic          mem_cke,   // clock enable
  input wire logic [0:0]    mem_cs_n,  // chip select
  input wire logic          mem_ras_n, // row strobe
  input wire logic          mem_cas_n, // column strobe
  input wire logic          mem_we_n,  // write enable
  input wire logic [1:0]    mem_ba,    // bank address
  input wire logic [AW-1:0] mem_addr   // address
);
  int q_code[$];
  int q_ba[$];
  int q_addr[$];
  int q_cyc[$];
  int cyc;
  int cke_cyc;
  int bad = 0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_code.delete();
      q_ba.delete();
      q_addr.delete();
      q_cyc.delete();
      cyc = 0;
      cke_cyc = -1;
    end else begin
      cyc++;
      if (mem_cke && cke_cyc < 0) cke_cyc = cyc;
      if (!mem_cs_n[0] && !(mem_ras_n && mem_cas_n && mem_we_n)) begin
        if (!mem_cke) bad++;
        q_code.push_back({mem_ras_n, mem_cas_n, mem_we_n});
        q_ba.push_back(mem_ba);
        q_addr.push_back(mem_addr);
        q_cyc.push_back(cyc);
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
/* self-checking bench for the init sequencer: apb master, dll stimulus.
   short startup counts; expected command list built per run. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int NS = 10;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
  logic        dqsupdate, capture_clk_sel, mem_cke, mem_ras_n, mem_cas_n, mem_we_n, init_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  dqs_delay_ctrl, dqs_delay_out, v;
  logic [0:0]  mem_cs_n;
  logic [1:0]  mem_ba;
  logic [12:0] mem_addr, mode, emode;
  int          miscompares = 0, tests_run = 0, cycles = 0;

  ddr_sdram_init_sequencer #(.DDR_STARTUP(NS), .DDR2_STARTUP(1000)) ddr_sdram_init_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .addrcmd_clk(pclk), .dqs_delay_ctrl(dqs_delay_ctrl), .dqsupdate(dqsupdate),
    .dqs_delay_out(dqs_delay_out), .capture_clk_sel(capture_clk_sel), .mem_cke(mem_cke),
    .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
    .mem_ba(mem_ba), .mem_addr(mem_addr), .init_done(init_done));
  mem_model #(.AW(13)) mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_cke(mem_cke),
    .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
    .mem_ba(mem_ba), .mem_addr(mem_addr));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // hang guard: whole run is well under this many cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("CHECK FAILED t=%0t timeout", $time);
      complete_run();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic run_seq(input bit d2);
    int ec[11], eg[11], eb[11], ea[11];
    int n, m, e1;
    mode  = 13'($urandom);
    emode = 13'($urandom);
    e1 = emode & 13'h1C7E;
    m = d2 ? 11 : 7;
    if (d2) begin
      ec = '{2, 0, 0, 0, 0, 2, 1, 1, 0, 0, 0};
      eg = '{0, 33, 33, 33, 33, 33, 33, 33, 33, 68, 33};
      eb = '{0, 2, 3, 1, 0, 0, 0, 0, 0, 1, 1};
      ea = '{-1, 0, 0, e1, mode | 13'h0100, -1, -1, -1, mode & 13'h1EFF, e1 | 13'h0380, e1};
    end else begin
      ec = '{2, 0, 0, 2, 1, 1, 0, 0, 0, 0, 0};
      eg = '{0, 33, 33, 200, 33, 33, 33, 0, 0, 0, 0};
      eb = '{0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0};
      ea = '{-1, e1, mode | 13'h0100, -1, -1, -1, mode & 13'h1EFF, -1, -1, -1, -1};
    end
    check_val(init_done, 0, "done after reset");
    apb(0, 12'h004, 0);
    check_val(rd, 32'h32, "mode reset value");
    apb(0, 12'h008, 0);
    check_val(rd, 32'h0, "emode reset value");
    apb(1, 12'h004, {19'h0, mode});
    apb(1, 12'h008, {19'h0, emode});
    apb(1, 12'h000, {30'h0, d2, 1'b1});
    while (init_done !== 1'b1) @(posedge pclk);
    @(posedge pclk);
    n = mem_model_inst.q_code.size();
    check_val(n, m, "command count");
    for (int i = 0; i < m && i < n; i++) begin
      check_val(mem_model_inst.q_code[i], ec[i], "command");
      if (ec[i] == 2) check_val((mem_model_inst.q_addr[i] >> 10) & 1, 1, "all banks");
      if (ea[i] >= 0) check_val(mem_model_inst.q_addr[i], ea[i], "load value");
      if (ea[i] >= 0) check_val(mem_model_inst.q_ba[i], eb[i], "load bank");
      if (i > 0) check_val(mem_model_inst.q_cyc[i] - mem_model_inst.q_cyc[i-1], eg[i], "spacing");
    end
    check_val(mem_model_inst.q_cyc[0] - mem_model_inst.cke_cyc >= (d2 ? 2 : NS - 1), 1, "startup wait");
    if (d2) check_val(mem_model_inst.cke_cyc > 1000, 1, "cke delay");
    if (d2) check_val(mem_model_inst.q_cyc[9] - mem_model_inst.q_cyc[4], 200, "ocd after dll reset");
    check_val(mem_model_inst.bad, 0, "command with cke low");
  endtask

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    dqs_delay_ctrl = 6'h00;
    dqsupdate = 1'b0;
    rd = $urandom(32'hA6EEDDF1);
    do_reset();
    run_seq(1'b0);
    $display("test 1 done: ddr sequence");
    do_reset();
    apb(1, 12'h000, 32'h1);
    while (mem_model_inst.q_code.size() < 3) @(posedge pclk);
    do_reset();
    run_seq(1'b1);
    $display("test 2 done: reset mid sequence, ddr2 sequence");
    apb(0, 12'h010, 0);
    check_val({31'h0, er}, 1, "unmapped read error");
    check_val(rd, 0, "unmapped read data");
    apb(1, 12'h002, 32'hFFFF);
    check_val({31'h0, er}, 1, "unaligned write error");
    apb(1, 12'h00C, 32'h0);
    check_val({31'h0, er}, 0, "status write");
    apb(1, 12'h000, 32'h5);
    repeat (2) @(posedge pclk);
    check_val(capture_clk_sel, 1, "capture select");
    apb(0, 12'h00C, 0);
    check_val(rd & 32'h73, 32'h53, "status done");
    $display("test 3 done: registers");
    for (int k = 0; k < 4; k++) begin
      v = 6'($urandom);
      dqs_delay_ctrl <= v;
      dqsupdate <= 1'b1;
      repeat (6) @(posedge pclk);
      check_val(dqs_delay_out, v, "delay follows");
      dqsupdate <= 1'b0;
      repeat (4) @(posedge pclk);
      dqs_delay_ctrl <= ~v;
      repeat (6) @(posedge pclk);
      check_val(dqs_delay_out, v, "delay held");
    end
    apb(0, 12'h00C, 0);
    check_val(rd[21:16], v, "status delay");
    ce <= 1'b0;
    repeat (2) @(posedge pclk);
    check_val(pready, 0, "stall");
    ce <= 1'b1;
    $display("test 4 done: delay control");
    complete_run();
  end
endmodule

bind ddr_sdram_init_sequencer seq_props #(.CS(CS), .AW(AW), .PCH_BIT(PCH_BIT)) seq_props_inst (
  .pclk(pclk), .presetn(presetn), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
  .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr),
  .init_done(init_done));
`default_nettype wire
